// ==== hdl/stp_pkg.sv ====
// Purpose: shared constants for the speech test serial port
// Assumes: 50 MHz system clock
// Notes: bit clock made by a 32-bit phase accumulator
package stp_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int BIT_CLK_HZ = 104000;
  localparam int WORD_BITS = 13;
  localparam int SAMPLE_RATE_HZ = 8000;
  localparam int SAMPLE_PERIOD_NS = 1000000000 / SAMPLE_RATE_HZ;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  // rounding error of the increment is far below the 20 ppm budget
  localparam logic [31:0] PHASE_INC =
    32'((64'(BIT_CLK_HZ) << 32) / 64'(CLK_HZ));
  localparam logic [3:0] LAST_BIT = 4'(WORD_BITS - 1);
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_DOWNLINK = 2'h1;
  localparam logic [1:0] MODE_UPLINK = 2'h2;
  localparam logic [1:0] MODE_ACOUSTIC = 2'h3;
  localparam logic [12:0] WORD_RST = 13'h0000;
  localparam logic [31:0] PHASE_RST = 32'h0000_0000;
  typedef enum logic {ST_IDLE, ST_BURST} stp_state_e;
endpackage

// ==== hdl/stp_speech_test_port.sv ====
// Purpose: handset end of the speech test serial port
// Assumes: tester pins are asynchronous and pass two flip-flops
// Notes: one thirteen-bit word per burst, one burst per sample period
// What this block does
// - 13-bit samples, 8000/s, 104 kbit/s serial
// - handset makes bit clock, only when needed
// - reset line resets transcoder and converters
// - bit clock 104 kHz within 20 ppm
// - reset line active when low
// - two's complement word, msb first
// - launch on falling, sample on rising edge
// - bit clock idles high
// - mode lines decode to four functions
// - mode may come from air command
// - only one selection method is used
// - clocking starts after reset release
// - uplink first falling edge requests first bit
// - downlink first edge outputs first decoded bit
// - transcoders reset at end of reset pulse
`timescale 1ns/1ps
module stp_speech_test_port #(
  parameter int SAMPLE_CYCLES = stp_pkg::SAMPLE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // tester pins
  input wire logic test_ctrl1,
  input wire logic test_ctrl2,
  input wire logic port_rst_n,
  input wire logic data_in,
  output logic data_out,
  output logic bit_clk,
  // mode from the air command path
  input wire logic use_air_mode,
  input wire logic [1:0] air_mode,
  // speech path status
  output logic [1:0] test_mode,
  output logic codec_rst,
  output logic codec_rst_done,
  // uplink samples taken from the tester
  output logic [12:0] ul_word,
  output logic ul_valid,
  // downlink samples given to the tester
  input wire logic [12:0] dl_word,
  input wire logic dl_valid,
  output logic dl_ready
);
  logic [1:0] c1_s_ff, c2_s_ff, rst_s_ff, din_s_ff;
  logic rst_prev_ff, armed_ff, nxt_armed;
  logic [1:0] mode_ff, nxt_mode;
  logic [31:0] ph_acc_ff, nxt_ph_acc;
  logic ph_prev_ff;
  stp_pkg::stp_state_e state_ff, nxt_state;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;
  logic [12:0] tx_sh_ff, nxt_tx_sh, rx_sh_ff, nxt_rx_sh;
  logic [12:0] smp_cnt_ff, nxt_smp_cnt;
  logic tick_pend_ff, nxt_tick_pend;
  logic [12:0] dl_buf_ff, nxt_dl_buf;
  logic dl_full_ff, nxt_dl_full;
  logic bit_clk_ff, nxt_bit_clk, data_out_ff, nxt_data_out;
  logic [12:0] ul_word_ff, nxt_ul_word;
  logic ul_valid_ff, nxt_ul_valid, codec_rst_ff, nxt_codec_rst;
  logic done_ff, nxt_done;
  logic [1:0] pin_mode, sel_mode;
  logic ph_rise, ph_fall, release_ev, go, start;

  function automatic logic [1:0] decode_mode(input logic c1, input logic c2);
    return {c1, c2};
  endfunction

  function automatic logic rx_dir(input logic [1:0] m);
    return (m == stp_pkg::MODE_UPLINK) || (m == stp_pkg::MODE_ACOUSTIC);
  endfunction

  function automatic logic tx_dir(input logic [1:0] m);
    return (m == stp_pkg::MODE_DOWNLINK) || (m == stp_pkg::MODE_ACOUSTIC);
  endfunction

  // pins pass two flip-flops before any logic looks at them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      c1_s_ff <= 2'h0;
      c2_s_ff <= 2'h0;
      // reset to the pin's idle level, or a false release would arm the port
      rst_s_ff <= 2'h3;
      din_s_ff <= 2'h0;
    end else if (clk_en) begin
      c1_s_ff <= {c1_s_ff[0], test_ctrl1};
      c2_s_ff <= {c2_s_ff[0], test_ctrl2};
      rst_s_ff <= {rst_s_ff[0], port_rst_n};
      din_s_ff <= {din_s_ff[0], data_in};
    end
  end

  assign pin_mode = decode_mode(c1_s_ff[1], c2_s_ff[1]);
  assign sel_mode = use_air_mode ? air_mode : pin_mode;

  // mode and arming
  always_comb begin
    nxt_mode = sel_mode;
    nxt_armed = armed_ff;
    nxt_codec_rst = 1'b0;
    nxt_done = 1'b0;
    if (!rst_s_ff[1]) begin
      nxt_codec_rst = 1'b1;
      nxt_armed = 1'b0;
    end else if (release_ev && sel_mode != stp_pkg::MODE_NORMAL) begin
      nxt_done = 1'b1;
      nxt_armed = 1'b1;
    end else if (sel_mode != mode_ff || sel_mode == stp_pkg::MODE_NORMAL) begin
      // a new mode shows on test_mode at once and disarms the port; bursts resume only after the next reset pulse
      nxt_armed = 1'b0;
    end
  end

  assign release_ev = rst_s_ff[1] && !rst_prev_ff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_prev_ff <= 1'b1;
      mode_ff <= stp_pkg::MODE_NORMAL;
      armed_ff <= 1'b0;
      codec_rst_ff <= 1'b1;
      done_ff <= 1'b0;
    end else if (clk_en) begin
      rst_prev_ff <= rst_s_ff[1];
      mode_ff <= nxt_mode;
      armed_ff <= nxt_armed;
      codec_rst_ff <= nxt_codec_rst;
      done_ff <= nxt_done;
    end
  end

  assign nxt_ph_acc = ph_acc_ff + stp_pkg::PHASE_INC;
  assign ph_rise = ph_acc_ff[31] && !ph_prev_ff;
  assign ph_fall = !ph_acc_ff[31] && ph_prev_ff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph_acc_ff <= stp_pkg::PHASE_RST;
      ph_prev_ff <= 1'b0;
    end else if (clk_en) begin
      ph_acc_ff <= nxt_ph_acc;
      ph_prev_ff <= ph_acc_ff[31];
    end
  end

  assign go = armed_ff && (rx_dir(mode_ff) ? tick_pend_ff : dl_full_ff);
  assign start = ph_rise && go && (state_ff == stp_pkg::ST_IDLE ||
                 (state_ff == stp_pkg::ST_BURST && bit_cnt_ff == stp_pkg::LAST_BIT));
  assign dl_ready = armed_ff && !dl_full_ff;

  // serial engine
  always_comb begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_smp_cnt = smp_cnt_ff;
    nxt_tick_pend = tick_pend_ff;
    nxt_dl_buf = dl_buf_ff;
    nxt_dl_full = dl_full_ff;
    nxt_data_out = data_out_ff;
    nxt_ul_word = ul_word_ff;
    nxt_ul_valid = 1'b0;
    if (dl_valid && dl_ready) begin
      nxt_dl_buf = dl_word;
      nxt_dl_full = 1'b1;
    end
    if (state_ff == stp_pkg::ST_BURST) begin
      case (1'b1)
        ph_fall: begin
          nxt_data_out = tx_sh_ff[12];
          nxt_tx_sh = {tx_sh_ff[11:0], 1'b0};
        end
        ph_rise: begin
          nxt_rx_sh = {rx_sh_ff[11:0], din_s_ff[1]};
          nxt_bit_cnt = bit_cnt_ff + 4'h1;
          if (bit_cnt_ff == stp_pkg::LAST_BIT) begin
            nxt_state = stp_pkg::ST_IDLE;
            if (rx_dir(mode_ff)) begin
              nxt_ul_word = {rx_sh_ff[11:0], din_s_ff[1]};
              nxt_ul_valid = 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (start) begin
      nxt_state = stp_pkg::ST_BURST;
      nxt_bit_cnt = 4'h0;
      nxt_tick_pend = 1'b0;
      nxt_tx_sh = tx_dir(mode_ff) && dl_full_ff ? dl_buf_ff : stp_pkg::WORD_RST;
      // a word taken in this very cycle is kept for the next burst
      if (tx_dir(mode_ff) && dl_full_ff) begin
        nxt_dl_full = 1'b0;
      end
    end
    if (armed_ff) begin
      if (smp_cnt_ff == 13'(SAMPLE_CYCLES - 1)) begin
        nxt_smp_cnt = 13'h0000;
        nxt_tick_pend = 1'b1;
      end else begin
        nxt_smp_cnt = smp_cnt_ff + 13'h0001;
      end
    end
    if (!armed_ff) begin
      nxt_state = stp_pkg::ST_IDLE;
      nxt_smp_cnt = 13'h0000;
      nxt_tick_pend = done_ff;
      nxt_dl_full = 1'b0;
      nxt_data_out = 1'b0;
    end else if (done_ff) begin
      // first uplink word is asked for right after release
      nxt_tick_pend = 1'b1;
    end
    nxt_bit_clk = (nxt_state == stp_pkg::ST_BURST) ? ph_acc_ff[31] : 1'b1;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= stp_pkg::ST_IDLE;
      bit_cnt_ff <= 4'h0;
      tx_sh_ff <= stp_pkg::WORD_RST;
      rx_sh_ff <= stp_pkg::WORD_RST;
      smp_cnt_ff <= 13'h0000;
      tick_pend_ff <= 1'b0;
      dl_buf_ff <= stp_pkg::WORD_RST;
      dl_full_ff <= 1'b0;
      data_out_ff <= 1'b0;
      bit_clk_ff <= 1'b1;
      ul_word_ff <= stp_pkg::WORD_RST;
      ul_valid_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      tx_sh_ff <= nxt_tx_sh;
      rx_sh_ff <= nxt_rx_sh;
      smp_cnt_ff <= nxt_smp_cnt;
      tick_pend_ff <= nxt_tick_pend;
      dl_buf_ff <= nxt_dl_buf;
      dl_full_ff <= nxt_dl_full;
      data_out_ff <= nxt_data_out;
      bit_clk_ff <= nxt_bit_clk;
      ul_word_ff <= nxt_ul_word;
      ul_valid_ff <= nxt_ul_valid;
    end
  end

  assign bit_clk = bit_clk_ff;
  assign data_out = data_out_ff;
  assign test_mode = mode_ff;
  assign codec_rst = codec_rst_ff;
  assign codec_rst_done = done_ff;
  assign ul_word = ul_word_ff;
  assign ul_valid = ul_valid_ff;
endmodule

// ==== bench/stp_properties.sv ====
// Purpose: port checks for the speech test port
// Assumes: 50 MHz clk, bit clock near 104 kHz
// Notes: bound to the design top below
`timescale 1ns/1ps
module stp_properties (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pins and status
  input wire logic port_rst_n,
  input wire logic bit_clk,
  input wire logic data_out,
  input wire logic [1:0] test_mode,
  input wire logic codec_rst,
  input wire logic ul_valid,
  input wire logic dl_valid,
  input wire logic dl_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_idle_hi; (test_mode == 2'h0) [*3] |-> bit_clk; endproperty
  a_idle_hi: assert property (p_idle_hi) else $error("clock low when idle");
  property p_dout; $changed(data_out) |-> $fell(bit_clk) || codec_rst || $past(codec_rst);
  endproperty
  a_dout: assert property (p_dout) else $error("data moved off falling edge");
  property p_half; $fell(bit_clk) |-> ##[230:250] $rose(bit_clk); endproperty
  a_half: assert property (p_half) else $error("low phase length");
  property p_ul_rise; ul_valid |-> bit_clk && !$past(bit_clk); endproperty
  a_ul_rise: assert property (p_ul_rise) else $error("word not after rise");
  property p_ul_mode; ul_valid |-> test_mode[1]; endproperty
  a_ul_mode: assert property (p_ul_mode) else $error("uplink word in wrong mode");
  property p_rst_hold; !port_rst_n [*5] |-> codec_rst; endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset not applied");
  property p_rst_free; port_rst_n [*5] |-> !codec_rst; endproperty
  a_rst_free: assert property (p_rst_free) else $error("reset stuck");
  property p_dl_take; dl_valid && dl_ready |=> !dl_ready; endproperty
  a_dl_take: assert property (p_dl_take) else $error("ready held after take");
  c_ul: cover property (ul_valid);
  c_dl: cover property (dl_valid && dl_ready);
  c_rst: cover property ($fell(codec_rst));
endmodule
bind stp_speech_test_port stp_properties u_chk (.clk, .sys_rst, .port_rst_n, .bit_clk,
  .data_out, .test_mode, .codec_rst, .ul_valid, .dl_valid, .dl_ready);

// ==== bench/stp_tester_model.sv ====
// Purpose: tester side of the serial link
// Assumes: bit clock comes from the handset
// Notes: outside frames data_in shows the inverse of its last bit
`timescale 1ns/1ps
module stp_tester_model (
  // link
  input wire logic rst,
  input wire logic bit_clk,
  input wire logic data_out,
  output logic data_in,
  // words
  input wire logic [12:0] tx_word,
  output logic [12:0] rx_word,
  output int rx_cnt
);
  int idx = 12;
  logic [12:0] sh = 13'h0000;
  initial data_in = 1'b0;
  initial rx_cnt = 0;
  always @(negedge bit_clk) data_in = tx_word[idx];
  always @(posedge bit_clk or posedge rst) begin
    if (rst) begin
      idx = 12;
    end else begin
      sh = {sh[11:0], data_out};
      idx = (idx == 0) ? 12 : idx - 1;
      if (idx == 12) begin
        rx_word = sh;
        rx_cnt++;
        data_in = ~data_in;
      end
    end
  end
endmodule

// ==== bench/stp_speech_test_port_bench.sv ====
// Purpose: self-checking bench for the speech test port
// Assumes: 50 MHz clk, inputs driven on falling clk edge
// Notes: mode settle and reset pulse are shortened; the block does not time them
`timescale 1ns/1ps
module stp_speech_test_port_bench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic test_ctrl1 = 1'b0;
  logic test_ctrl2 = 1'b0;
  logic port_rst_n = 1'b1;
  logic use_air_mode = 1'b0;
  logic [1:0] air_mode = 2'h0;
  logic [12:0] dl_word = 13'h0000;
  logic dl_valid = 1'b0;
  logic [12:0] tx = 13'h1a5c;
  logic data_in, data_out, bit_clk, codec_rst, codec_rst_done, ul_valid, dl_ready;
  logic [1:0] test_mode;
  logic [12:0] ul_word, rx_word;
  int rx_cnt, n_fall, n_ul, n_done, cyc, err_count, total_checks;
  always #10 clk = ~clk;
  stp_speech_test_port DUT (.clk, .sys_rst, .clk_en(1'b1), .test_ctrl1, .test_ctrl2,
    .port_rst_n, .data_in, .data_out, .bit_clk, .use_air_mode, .air_mode, .test_mode,
    .codec_rst, .codec_rst_done, .ul_word, .ul_valid, .dl_word, .dl_valid, .dl_ready);
  stp_tester_model u_tester (.rst(sys_rst), .bit_clk, .data_out, .data_in, .tx_word(tx),
    .rx_word, .rx_cnt);
  always @(negedge bit_clk) n_fall++;
  always @(posedge clk) begin
    cyc++;
    n_ul += (ul_valid === 1'b1);
    n_done += (codec_rst_done === 1'b1);
    if (cyc == 60000) begin
      err_count++;
      end_sim;
    end
  end
  task automatic chk(string nm, logic [12:0] exp, logic [12:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wait_n(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic do_reset;
    sys_rst = 1'b1;
    wait_n(12);
    chk("rst", 13'h0021, 13'({bit_clk, data_out, dl_ready, test_mode, codec_rst}));
    sys_rst = 1'b0;
  endtask
  task automatic arm(logic [1:0] m);
    int d0;
    d0 = n_done;
    {test_ctrl1, test_ctrl2} = m;
    wait_n(20);
    port_rst_n = 1'b0;
    wait_n(20);
    chk("codec_rst", 13'h0001, 13'(codec_rst));
    port_rst_n = 1'b1;
    wait_n(6);
    chk("rst_done", 13'(m != 2'h0), 13'(n_done - d0));
  endtask
  task automatic t_normal;
    int f0;
    do_reset;
    arm(2'h0);
    f0 = n_fall;
    wait_n(1500);
    chk("falls", 13'h0000, 13'(n_fall - f0));
    $display("normal done");
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      {test_ctrl1, test_ctrl2} = 2'(m);
      wait_n(4);
      chk("mode", 13'(m), 13'(test_mode));
    end
    use_air_mode = 1'b1;
    air_mode = 2'h2;
    wait_n(2);
    chk("air", 13'h0002, 13'(test_mode));
    use_air_mode = 1'b0;
    $display("modes done");
  endtask
  task automatic wait_ul;
    int k;
    k = 0;
    while (ul_valid !== 1'b1 && k < 14000) begin
      wait_n(1);
      k++;
    end
    wait_n(1);
  endtask
  task automatic t_uplink;
    int f0, c0;
    do_reset;
    arm(2'h2);
    wait_ul;
    chk("ul0", 13'h1a5c, ul_word);
    f0 = n_fall;
    c0 = cyc;
    tx = 13'h0a35;
    wait_ul;
    chk("ul1", 13'h0a35, ul_word);
    chk("bits", 13'h000d, 13'(n_fall - f0));
    chk("tick", 13'h0001, 13'(cyc - c0 > 6230 && cyc - c0 < 6270));
    $display("uplink done");
  endtask
  task automatic t_down;
    int r0, u0, k;
    do_reset;
    arm(2'h1);
    r0 = rx_cnt;
    u0 = n_ul;
    dl_word = 13'h1357;
    dl_valid = 1'b1;
    k = 0;
    while (dl_ready !== 1'b1 && k < 200) begin
      wait_n(1);
      k++;
    end
    wait_n(1);
    dl_valid = 1'b0;
    chk("dl_ready", 13'h0000, 13'(dl_ready));
    k = 0;
    while (rx_cnt == r0 && k < 8000) begin
      wait_n(1);
      k++;
    end
    chk("dl", 13'h1357, rx_word);
    chk("no_ul", 13'h0000, 13'(n_ul - u0));
    $display("downlink done");
  endtask
  // both directions: the word offered during burst two leaves in burst three
  task automatic t_acoustic;
    int r0, k;
    tx = 13'h15a3;
    do_reset;
    arm(2'h3);
    wait_ul;
    chk("ac_ul", 13'h15a3, ul_word);
    chk("ac_ready", 13'h0001, 13'(dl_ready));
    r0 = rx_cnt;
    dl_word = 13'h0c6e;
    dl_valid = 1'b1;
    wait_n(1);
    dl_valid = 1'b0;
    k = 0;
    while (rx_cnt - r0 < 2 && k < 14000) begin
      wait_n(1);
      k++;
    end
    chk("ac_dl", 13'h0c6e, rx_word);
    $display("acoustic done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    t_normal;
    t_modes;
    t_uplink;
    t_down;
    t_acoustic;
    end_sim;
  end
endmodule
